// ---- design/ofr_pkg.sv ----
/*
 * constants for the output fault response block: command codes, field
 * layout of the response bytes, encodings, reset values and the tick time.
 * assumes a 10 MHz system clock.
 */
package ofr_pkg;

	// clock and tick timing
	localparam int unsigned CLK_FREQ_MHZ = 10;
	localparam int unsigned TICK_TIME_US = 10;
	localparam int unsigned TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;

	// command codes
	localparam logic [7:0] CMD_OC_RESP = 8'h47;
	localparam logic [7:0] CMD_UV_RESP = 8'hE0;
	localparam logic [7:0] CMD_TON_RESP = 8'hE1;
	localparam logic [7:0] CMD_RETRY_INT = 8'hE2;
	localparam logic [7:0] CMD_CLEAR = 8'h03;

	// response byte fields
	localparam int unsigned RESP_HI = 7;
	localparam int unsigned RESP_LO = 6;
	localparam int unsigned RETRY_HI = 5;
	localparam int unsigned RETRY_LO = 3;
	localparam int unsigned DELAY_HI = 2;
	localparam int unsigned DELAY_LO = 0;

	// response and retry encodings
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DELAY = 2'h1;
	localparam logic [1:0] RESP_SHUT = 2'h2;
	localparam logic [1:0] RESP_BAD = 2'h3;
	localparam logic [1:0] OC_RESP_BAD = 2'h1;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [7:0] TON_RESP_OFF = 8'h00;

	// reset values
	localparam logic [7:0] OC_RESP_RESET = 8'h00;
	localparam logic [7:0] UV_RESP_RESET = 8'h80;
	localparam logic [7:0] TON_RESP_RESET = 8'h80;
	localparam logic [7:0] RETRY_INT_RESET = 8'h0A;
	localparam logic [7:0] READ_NONE = 8'h00;

	// response state machine
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_DELAY = 4'h2,
		ST_SHUT = 4'h4,
		ST_RETRY = 4'h8
	} ofr_state_t;

endpackage

// ---- design/ofr_tick.sv ----
/*
 * 10 us tick divider for the fault delay and retry counters.
 * assumes one clock, synchronous active-high reset; restart realigns phase.
 */
`timescale 1ns/1ps
`default_nettype none

module ofr_tick import ofr_pkg::*; #(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restart,
	// tick out
	output logic tick
);

	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_tick;

	// divider
	always_comb begin
		next_cnt = cnt + 1'b1;
		next_tick = 1'b0;
		if (restart) begin
			next_cnt = '0;
		end else if (cnt == LAST) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

endmodule

`default_nettype wire

// ---- design/ofr_core.sv ----
/*
 * output fault response logic for one channel: response bytes, undervoltage
 * masking, delay, shut-off and retry, turn-on timeout flags, alert.
 * assumes synchronous inputs from the sequencer and comparators, a host
 * command port decoded from the serial interface, 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ofr_core import ofr_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter logic [7:0] UV_RESP_INIT = UV_RESP_RESET,
	parameter logic [7:0] TON_RESP_INIT = TON_RESP_RESET,
	parameter logic [7:0] RETRY_INT_INIT = RETRY_INT_RESET
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// host command port
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STROBE,
	input wire logic [7:0] WR_DATA,
	output logic [7:0] RD_DATA,
	// channel command
	input wire logic CHANNEL_RUN_PIN,
	input wire logic OPERATION_ON,
	// sequencer state
	input wire logic TON_MAX_REACHED,
	input wire logic TON_DELAY_DONE,
	input wire logic TON_RISE_DONE,
	input wire logic TOFF_FALL_ACTIVE,
	input wire logic TON_TIMEOUT,
	// comparators
	input wire logic UV_DETECT,
	input wire logic VOUT_ABOVE_UV,
	input wire logic OC_PRESENT,
	// alert masks
	input wire logic UV_ALERT_MASK,
	input wire logic TON_ALERT_MASK,
	// status and control out
	output logic OUTPUT_ENABLE,
	output logic ALERT_N,
	output logic UV_FAULT,
	output logic TON_FAULT,
	output logic STATUS_WORD_VOUT,
	output logic STATUS_BYTE_NOTA,
	output logic CML_FAULT
);

	function automatic logic [1:0] resp_field(input logic [7:0] b);
		resp_field = b[RESP_HI:RESP_LO];
	endfunction

	// response byte registers
	logic [7:0] oc_resp;
	logic [7:0] uv_resp;
	logic [7:0] ton_resp;
	logic [7:0] retry_int;
	logic [7:0] next_oc_resp;
	logic [7:0] next_uv_resp;
	logic [7:0] next_ton_resp;
	logic [7:0] next_retry_int;
	logic [7:0] next_rd_data;
	logic cml_set;

	// fault state
	ofr_state_t state;
	ofr_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic uv_armed;
	logic next_uv_armed;
	logic run_prev;
	logic uv_flag;
	logic ton_flag;
	logic nota_flag;
	logic word_flag;
	logic alert_n;
	logic cml;
	logic out_en;
	logic next_uv_flag;
	logic next_ton_flag;
	logic next_nota_flag;
	logic next_word_flag;
	logic next_alert_n;
	logic next_cml;
	logic next_out_en;

	// shared terms
	logic run_cmd;
	logic clear_cmd;
	logic fault_clear;
	logic uv_enable;
	logic uv_event;
	logic ton_event;
	logic tick;
	logic tick_restart;
	logic [2:0] delay_n;
	logic [2:0] retry_set;

	assign run_cmd = CHANNEL_RUN_PIN & OPERATION_ON;
	assign clear_cmd = WR_STROBE & (CMD_CODE == CMD_CLEAR);
	assign fault_clear = clear_cmd | (run_cmd & ~run_prev);
	assign delay_n = uv_resp[DELAY_HI:DELAY_LO];
	assign retry_set = uv_resp[RETRY_HI:RETRY_LO];
	assign uv_enable = uv_armed & run_cmd & TON_RISE_DONE & ~TOFF_FALL_ACTIVE
		& ((state == ST_RUN) | (state == ST_DELAY));
	assign uv_event = UV_DETECT & uv_enable;
	assign ton_event = TON_TIMEOUT & run_cmd & (ton_resp != TON_RESP_OFF);
	assign tick_restart = (state != next_state);

	ofr_tick #(
		.CYCLES(TICK_LEN)
	) ofr_tick_inst (
		.clk(CLK),
		.rst(RST),
		.restart(tick_restart),
		.tick(tick)
	);

	// host writes and reads
	always_comb begin
		next_oc_resp = oc_resp;
		next_uv_resp = uv_resp;
		next_ton_resp = ton_resp;
		next_retry_int = retry_int;
		cml_set = 1'b0;
		if (WR_STROBE) begin
			case (CMD_CODE)
				CMD_OC_RESP: begin
					if (resp_field(WR_DATA) == OC_RESP_BAD) begin
						cml_set = 1'b1;
					end else begin
						next_oc_resp = WR_DATA;
					end
				end
				CMD_UV_RESP: begin
					if (resp_field(WR_DATA) == RESP_BAD) begin
						cml_set = 1'b1;
					end else begin
						next_uv_resp = WR_DATA;
					end
				end
				CMD_TON_RESP: next_ton_resp = WR_DATA;
				CMD_RETRY_INT: next_retry_int = WR_DATA;
				CMD_CLEAR: cml_set = 1'b0;
				default: cml_set = 1'b1;
			endcase
		end
		case (CMD_CODE)
			CMD_OC_RESP: next_rd_data = oc_resp;
			CMD_UV_RESP: next_rd_data = uv_resp;
			CMD_TON_RESP: next_rd_data = ton_resp;
			CMD_RETRY_INT: next_rd_data = retry_int;
			default: next_rd_data = READ_NONE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			oc_resp <= OC_RESP_RESET;
			uv_resp <= UV_RESP_INIT;
			ton_resp <= TON_RESP_INIT;
			retry_int <= RETRY_INT_INIT;
			RD_DATA <= READ_NONE;
		end else begin
			oc_resp <= next_oc_resp;
			uv_resp <= next_uv_resp;
			ton_resp <= next_ton_resp;
			retry_int <= next_retry_int;
			RD_DATA <= next_rd_data;
		end
	end

	// masking, response state machine, delay and retry counting
	always_comb begin
		next_state = state;
		next_cnt = tick ? cnt + 1'b1 : cnt;
		next_uv_armed = run_cmd & (uv_armed | (TON_MAX_REACHED & TON_DELAY_DONE
			& TON_RISE_DONE & VOUT_ABOVE_UV & ~OC_PRESENT));
		case (state)
			ST_RUN: begin
				next_cnt = '0;
				if (ton_event && resp_field(ton_resp) != RESP_IGNORE) begin
					next_state = ST_SHUT;
				end else if (uv_event) begin
					case (resp_field(uv_resp))
						RESP_DELAY: next_state = ST_DELAY;
						RESP_SHUT: next_state = ST_SHUT;
						default: next_state = ST_RUN;
					endcase
				end
			end
			ST_DELAY: begin
				if (!uv_event) begin
					next_state = ST_RUN;
					next_cnt = '0;
				end else if (cnt >= {5'h00, delay_n}) begin
					next_state = ST_SHUT;
				end
			end
			ST_SHUT: begin
				next_cnt = '0;
				if (retry_set == RETRY_FOREVER) begin
					next_state = ST_RETRY;
				end else if (fault_clear) begin
					next_state = ST_RUN;
				end
			end
			ST_RETRY: begin
				if (cnt >= retry_int) begin
					next_state = ST_RUN;
					next_cnt = '0;
				end
			end
			default: begin
				next_state = ST_RUN;
				next_cnt = '0;
			end
		endcase
		if (!run_cmd) begin
			next_state = ST_RUN;
			next_cnt = '0;
		end
		if (next_state == ST_SHUT || next_state == ST_RETRY) begin
			next_uv_armed = 1'b0;
		end
		next_out_en = run_cmd & ((next_state == ST_RUN) | (next_state == ST_DELAY));
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ST_RUN;
			cnt <= '0;
			uv_armed <= 1'b0;
			out_en <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			uv_armed <= next_uv_armed;
			out_en <= next_out_en;
		end
	end

	// sticky status flags and alert, set wins over clear
	always_comb begin
		next_uv_flag = (uv_flag & ~fault_clear) | uv_event;
		next_ton_flag = (ton_flag & ~fault_clear) | ton_event;
		next_nota_flag = (nota_flag & ~fault_clear) | ton_event;
		next_word_flag = (word_flag & ~fault_clear) | uv_event | ton_event;
		next_alert_n = ~((~alert_n & ~fault_clear) | (uv_event & ~UV_ALERT_MASK)
			| (ton_event & ~TON_ALERT_MASK) | cml_set);
		next_cml = (cml & ~clear_cmd) | cml_set;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			uv_flag <= 1'b0;
			ton_flag <= 1'b0;
			nota_flag <= 1'b0;
			word_flag <= 1'b0;
			alert_n <= 1'b1;
			cml <= 1'b0;
			run_prev <= 1'b0;
		end else begin
			uv_flag <= next_uv_flag;
			ton_flag <= next_ton_flag;
			nota_flag <= next_nota_flag;
			word_flag <= next_word_flag;
			alert_n <= next_alert_n;
			cml <= next_cml;
			run_prev <= run_cmd;
		end
	end

	// outputs straight from flops
	assign OUTPUT_ENABLE = out_en;
	assign ALERT_N = alert_n;
	assign UV_FAULT = uv_flag;
	assign TON_FAULT = ton_flag;
	assign STATUS_WORD_VOUT = word_flag;
	assign STATUS_BYTE_NOTA = nota_flag;
	assign CML_FAULT = cml;

endmodule

`default_nettype wire

// ---- verification/ofr_host.sv ----
/* host model: single-byte writes and reads on the command port.
   assumes ofr_core host port timing, inputs driven at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ofr_host (
	// clock
	input wire logic CLK,
	// command port
	output logic [7:0] CMD_CODE,
	output logic WR_STROBE,
	output logic [7:0] WR_DATA,
	input wire logic [7:0] RD_DATA
);
	initial begin
		CMD_CODE = 8'h00;
		WR_STROBE = 1'b0;
		WR_DATA = 8'h00;
	end
	task automatic wr(input logic [7:0] code, input logic [7:0] data);
		@(negedge CLK);
		CMD_CODE = code;
		WR_DATA = data;
		WR_STROBE = 1'b1;
		@(negedge CLK);
		WR_STROBE = 1'b0;
		WR_DATA = ~data;
	endtask
	task automatic rd(input logic [7:0] code, output logic [7:0] data);
		@(negedge CLK);
		CMD_CODE = code;
		@(negedge CLK);
		data = RD_DATA;
	endtask
endmodule
`default_nettype wire

// ---- verification/ofr_properties.sv ----
/* port checker for ofr_core.
   assumes one clock and the ofr_pkg encodings. */
`timescale 1ns/1ps
`default_nettype none
module ofr_properties import ofr_pkg::*; (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// inputs
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STROBE,
	input wire logic [7:0] WR_DATA,
	input wire logic CHANNEL_RUN_PIN,
	input wire logic OPERATION_ON,
	input wire logic TON_RISE_DONE,
	input wire logic TOFF_FALL_ACTIVE,
	input wire logic TON_TIMEOUT,
	input wire logic UV_ALERT_MASK,
	input wire logic TON_ALERT_MASK,
	// outputs
	input wire logic OUTPUT_ENABLE,
	input wire logic ALERT_N,
	input wire logic UV_FAULT,
	input wire logic TON_FAULT,
	input wire logic STATUS_WORD_VOUT,
	input wire logic STATUS_BYTE_NOTA,
	input wire logic CML_FAULT
);
	logic [7:0] uv_r;
	logic [7:0] ton_r;
	logic run;
	logic clr;
	assign run = CHANNEL_RUN_PIN & OPERATION_ON;
	assign clr = WR_STROBE && CMD_CODE == CMD_CLEAR;
	always_ff @(posedge CLK) begin
		if (RST) begin
			uv_r <= UV_RESP_RESET;
			ton_r <= TON_RESP_RESET;
		end else if (WR_STROBE && CMD_CODE == CMD_UV_RESP && WR_DATA[7:6] != RESP_BAD) begin
			uv_r <= WR_DATA;
		end else if (WR_STROBE && CMD_CODE == CMD_TON_RESP) begin
			ton_r <= WR_DATA;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_uv; $rose(UV_FAULT); endsequence
	sequence s_hold; UV_FAULT && run && $past(run) && !clr; endsequence
	property p_flags; s_uv |-> STATUS_WORD_VOUT && (!ALERT_N || $past(UV_ALERT_MASK)); endproperty
	a_flags: assert property (p_flags) else $error("uv flags");
	property p_idle; !run && !UV_FAULT |=> !UV_FAULT; endproperty
	a_idle: assert property (p_idle) else $error("uv while inactive");
	property p_ramp; (TOFF_FALL_ACTIVE || !TON_RISE_DONE) && !UV_FAULT |=> !UV_FAULT; endproperty
	a_ramp: assert property (p_ramp) else $error("uv during ramp");
	property p_shut; (s_uv and (uv_r[7:6] == RESP_SHUT)) |-> !OUTPUT_ENABLE; endproperty
	a_shut: assert property (p_shut) else $error("no shutdown");
	property p_delay;
		(s_uv and (uv_r[7:6] == RESP_DELAY && uv_r[2:0] != 3'h0)) |-> OUTPUT_ENABLE[*4];
	endproperty
	a_delay: assert property (p_delay) else $error("early shutdown");
	property p_cml; WR_STROBE && CMD_CODE == CMD_UV_RESP && WR_DATA[7:6] == RESP_BAD |=> CML_FAULT && !ALERT_N; endproperty
	a_cml: assert property (p_cml) else $error("no cml fault");
	property p_hold; s_hold |=> UV_FAULT; endproperty
	a_hold: assert property (p_hold) else $error("uv flag lost");
	property p_ton; TON_TIMEOUT && run && ton_r != TON_RESP_OFF && !TON_ALERT_MASK |=> TON_FAULT && STATUS_BYTE_NOTA && STATUS_WORD_VOUT && !ALERT_N; endproperty
	a_ton: assert property (p_ton) else $error("timeout flags");
	property p_retry; $fell(OUTPUT_ENABLE) && run && uv_r[5:3] == RETRY_FOREVER |-> ##[1:1000] OUTPUT_ENABLE; endproperty
	a_retry: assert property (p_retry) else $error("no restart");
endmodule
bind ofr_core ofr_properties ofr_properties_inst (.CLK, .RST, .CMD_CODE, .WR_STROBE, .WR_DATA,
	.CHANNEL_RUN_PIN, .OPERATION_ON, .TON_RISE_DONE, .TOFF_FALL_ACTIVE, .TON_TIMEOUT,
	.UV_ALERT_MASK, .TON_ALERT_MASK, .OUTPUT_ENABLE, .ALERT_N, .UV_FAULT, .TON_FAULT,
	.STATUS_WORD_VOUT, .STATUS_BYTE_NOTA, .CML_FAULT);
`default_nettype wire

// ---- verification/ofr_core_tb.sv ----
/* self-checking bench for ofr_core with a host model.
   assumes a 10 MHz clock and a shortened tick of 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
module ofr_core_tb import ofr_pkg::*;;
	localparam int TL = 4;
	localparam logic [1:0] RESPS [4] = '{RESP_IGNORE, RESP_SHUT, RESP_DELAY, RESP_DELAY};
	logic CLK, RST, WR_STROBE, CHANNEL_RUN_PIN, OPERATION_ON, TON_MAX_REACHED, TON_DELAY_DONE;
	logic TON_RISE_DONE, TOFF_FALL_ACTIVE, TON_TIMEOUT, UV_DETECT, VOUT_ABOVE_UV, OC_PRESENT;
	logic UV_ALERT_MASK, TON_ALERT_MASK, OUTPUT_ENABLE, ALERT_N, UV_FAULT, TON_FAULT;
	logic STATUS_WORD_VOUT, STATUS_BYTE_NOTA, CML_FAULT;
	logic [7:0] CMD_CODE, WR_DATA, RD_DATA, rv, got;
	int n_fail, comparisons, n, cyc;
	ofr_host ofr_host_inst (.CLK, .CMD_CODE, .WR_STROBE, .WR_DATA, .RD_DATA);
	ofr_core #(.TICK_LEN(TL)) ofr_core_inst (.CLK, .RST, .CMD_CODE, .WR_STROBE, .WR_DATA,
		.RD_DATA, .CHANNEL_RUN_PIN, .OPERATION_ON, .TON_MAX_REACHED, .TON_DELAY_DONE,
		.TON_RISE_DONE, .TOFF_FALL_ACTIVE, .TON_TIMEOUT, .UV_DETECT, .VOUT_ABOVE_UV, .OC_PRESENT,
		.UV_ALERT_MASK, .TON_ALERT_MASK, .OUTPUT_ENABLE, .ALERT_N, .UV_FAULT, .TON_FAULT,
		.STATUS_WORD_VOUT, .STATUS_BYTE_NOTA, .CML_FAULT);
	always #50 CLK = ~CLK;
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// cycles from fault to output off that the response allows
	function automatic logic in_win(input logic [1:0] resp, input int k, input int c);
		if (resp == RESP_IGNORE) return c == 40;
		if (resp == RESP_SHUT) return c == 1;
		if (k == 0) return c == 2;
		return c >= TL * k && c <= TL * k + 5;
	endfunction
	task automatic up(input logic above);
		@(negedge CLK);
		{CHANNEL_RUN_PIN, OPERATION_ON, TON_MAX_REACHED, TON_DELAY_DONE, TON_RISE_DONE} = 5'h1F;
		VOUT_ABOVE_UV = above;
		repeat (3) @(negedge CLK);
	endtask
	task automatic down();
		@(negedge CLK);
		{CHANNEL_RUN_PIN, UV_DETECT, OPERATION_ON} = 3'h1;
		repeat (2) @(negedge CLK);
	endtask
	initial begin
		repeat (5000) @(posedge CLK);
		n_fail++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		{CLK, RST} = 2'h1;
		{CHANNEL_RUN_PIN, OPERATION_ON, TON_MAX_REACHED, TON_DELAY_DONE} = 4'h0;
		{TON_RISE_DONE, TOFF_FALL_ACTIVE, TON_TIMEOUT, UV_DETECT, VOUT_ABOVE_UV} = 5'h00;
		{OC_PRESENT, UV_ALERT_MASK, TON_ALERT_MASK} = 3'h0;
		void'($urandom(32'h1c34));
		repeat (6) @(posedge CLK);
		@(negedge CLK) RST = 1'b0;
		ofr_host_inst.rd(CMD_OC_RESP, rv); chk("oc_reset", rv, OC_RESP_RESET);
		ofr_host_inst.rd(8'h7F, rv); chk("unmapped", rv, READ_NONE);
		rv = {1'b1, 7'($urandom)};
		ofr_host_inst.wr(CMD_OC_RESP, rv);
		ofr_host_inst.wr(CMD_OC_RESP, {OC_RESP_BAD, 6'h00}); chk("cml_oc", CML_FAULT, 1);
		ofr_host_inst.rd(CMD_OC_RESP, got); chk("oc_keep", got, rv);
		ofr_host_inst.wr(CMD_CLEAR, 8'h00); chk("cml_clr", CML_FAULT, 0);
		ofr_host_inst.wr(CMD_UV_RESP, {RESP_BAD, 6'h00}); chk("cml_uv", CML_FAULT, 1);
		ofr_host_inst.rd(CMD_UV_RESP, rv); chk("uv_keep", rv, UV_RESP_RESET);
		ofr_host_inst.wr(CMD_CLEAR, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			n = (i == 3) ? 0 : int'($urandom_range(7, 1));
			ofr_host_inst.wr(CMD_UV_RESP, {RESPS[i], 3'h0, 3'(n)});
			UV_ALERT_MASK = (i == 1);
			up(1'b1);
			UV_DETECT = 1'b1;
			@(negedge CLK);
			chk("uv_fault", {UV_FAULT, STATUS_WORD_VOUT, ALERT_N}, {2'h3, UV_ALERT_MASK});
			chk("oe_now", OUTPUT_ENABLE, RESPS[i] != RESP_SHUT);
			for (cyc = 1; OUTPUT_ENABLE === 1'b1 && cyc < 40; cyc++) @(negedge CLK);
			chk("oe_late", in_win(RESPS[i], n, cyc), 1);
			repeat (20) @(negedge CLK);
			chk("stay", {OUTPUT_ENABLE, UV_FAULT}, {RESPS[i] == RESP_IGNORE, 1'b1});
			UV_DETECT = 1'b0;
			ofr_host_inst.wr(CMD_CLEAR, 8'h00); chk("uv_clr", UV_FAULT, 0);
			down();
			$display("test response %0d done", i);
		end
		ofr_host_inst.wr(CMD_RETRY_INT, 8'h03);
		ofr_host_inst.wr(CMD_UV_RESP, {RESP_SHUT, RETRY_FOREVER, 3'h0});
		up(1'b1);
		UV_DETECT = 1'b1;
		@(negedge CLK) UV_DETECT = 1'b0;
		for (cyc = 0; OUTPUT_ENABLE !== 1'b1 && cyc < 100; cyc++) @(negedge CLK);
		chk("retry", cyc >= 3 * TL && cyc <= 3 * TL + 6, 1);
		down();
		up(1'b0);
		UV_DETECT = 1'b1;
		repeat (3) @(negedge CLK); chk("unarmed", UV_FAULT, 0);
		{VOUT_ABOVE_UV, OC_PRESENT} = 2'h3;
		repeat (3) @(negedge CLK); chk("oc_mask", UV_FAULT, 0);
		{OC_PRESENT, TOFF_FALL_ACTIVE} = 2'h1;
		repeat (3) @(negedge CLK); chk("fall", UV_FAULT, 0);
		{OPERATION_ON, TOFF_FALL_ACTIVE} = 2'h0;
		repeat (3) @(negedge CLK); chk("off", UV_FAULT, 0);
		down();
		$display("test masking done");
		ofr_host_inst.wr(CMD_TON_RESP, TON_RESP_OFF);
		up(1'b1);
		TON_TIMEOUT = 1'b1;
		@(negedge CLK) TON_TIMEOUT = 1'b0;
		chk("ton_off", TON_FAULT, 0);
		ofr_host_inst.wr(CMD_TON_RESP, 8'($urandom_range(63, 1)));
		TON_TIMEOUT = 1'b1;
		@(negedge CLK) TON_TIMEOUT = 1'b0;
		chk("ton", {TON_FAULT, STATUS_BYTE_NOTA, STATUS_WORD_VOUT, ALERT_N}, 4'hE);
		down();
		$display("test timeout done");
		give_verdict();
	end
endmodule
`default_nettype wire
